// ===== rtl/acrb_pkg.sv
// =====================================================================
// Shared constants of the amplifier control register bank
package acrb_pkg;

    // =================================================================
    // Register indices on the command port
    localparam logic [3:0] ADDR_GAIN    = 4'h0;
    localparam logic [3:0] ADDR_SRST    = 4'h1;
    localparam logic [3:0] ADDR_CPOL    = 4'h2;
    localparam logic [3:0] ADDR_ONTIME  = 4'h3;
    localparam logic [3:0] ADDR_ERR     = 4'h4;
    localparam logic [3:0] ADDR_DATA    = 4'h5;
    localparam logic [3:0] ADDR_SW1     = 4'h6;
    localparam logic [3:0] ADDR_SW2     = 4'h7;
    localparam logic [3:0] ADDR_DIR     = 4'h8;
    localparam logic [3:0] ADDR_EXTCS   = 4'h9;
    localparam logic [3:0] ADDR_CFG1    = 4'ha;
    localparam logic [3:0] ADDR_CFG2    = 4'hb;
    localparam logic [3:0] ADDR_SFUNC   = 4'hc;
    localparam logic [3:0] ADDR_TEST_LO = 4'hd;

    // =================================================================
    // Values after reset (power-on and soft reset alike)
    localparam logic [7:0] RST_GAIN   = 8'h00;
    localparam logic [5:0] RST_ONTIME = 6'h19;
    localparam logic [6:0] RST_SW1    = 7'h60;
    localparam logic [7:0] RST_CFG2   = 8'h10;
    localparam logic [7:0] CFG2_WMASK = 8'hbd;

    // =================================================================
    // Field positions
    localparam int ERR_CHK  = 7;
    localparam int ERR_IAR  = 6;
    localparam int ERR_BUFON = 5;
    localparam int ERR_ICA  = 4;
    localparam int ERR_SUM  = 3;
    localparam int ERR_OUT  = 2;
    localparam int ERR_GAIN = 1;
    localparam int ERR_IOV  = 0;
    localparam int CFG1_SELDIS  = 7;
    localparam int CFG1_BUFPOL  = 5;
    localparam int CFG1_KEEPERR = 3;
    localparam int CFG2_LTD     = 7;
    localparam int CFG2_CHKEN   = 0;
    localparam int SF_OSC   = 7;
    localparam int SF_SYNC  = 6;
    localparam int SF_BUFO  = 5;
    localparam int SF_BUFT  = 4;
    localparam int SF_EFO   = 3;
    localparam logic [3:0] GAIN_CODE_MAX = 4'ha;
    localparam logic [7:0] ERR_SRC_MASK  = 8'h57;

    // =================================================================
    // Timing
    localparam int unsigned CLK_NS          = 4;
    localparam int unsigned TICK_NS         = 1000;
    localparam int unsigned TICK_CYC        = TICK_NS / CLK_NS;
    localparam int unsigned BUF_STEP_TICKS  = 4;
    localparam int unsigned BUF_HOLD_TICKS  = 4;
    localparam int unsigned OUT_DLY_NS      = 6000;
    localparam int unsigned OUT_DLY_CYC     = OUT_DLY_NS / CLK_NS;

endpackage : acrb_pkg

// ===== rtl/acrb_top.sv
// Notes on behaviour
// R1: Gain top bit picks 1 or 1.375 output
// R2: Four-bit input gain code, 1011-1111 reserved
// R3: Low gain bits steer external selector pins
// R4: Gain read 0x8000, write 0x40, trigger 0x60
// R5: Soft reset bit resets all, self-clears
// R6: Power-on defaults equal soft reset values
// R7: Clock phase bit per enabled extended select
// R8: Timeout step four ticks, zero disables buffer
// R9: Minimum about 4 us, reset 100 us
// R10: Error bit 5 shows buffer active
// R11: Flags set on event, write-one clears
// R12: Checksum fault only when protection enabled
// R13: Summary is OR of unmasked error sources
// R14: Output-stage fault waits about 6 us
// R15: Blank bits ignore writes, read zero
// R16: Addresses 13 to 15 read-only
// R17: Direction 1 output, 0 input, reset input
// R18: Extended-select bit enables select on pin
// R19: Data register drives outputs, samples inputs
// R20: Bits 6..0 map to pins 6..0
// R21: Config top bit stops selector drive
// R22: Config mask removes source, not checksum
// R23: Suppress code linear to 8, then steps
// R24: Checksum required until disabled or reset
`timescale 1ns/100ps
`default_nettype none

module acrb_top
    import acrb_pkg::*;
(
    input  wire logic       CLK_SYS,
    input  wire logic       SRST,
    input  wire logic       REQ_VALID,
    input  wire logic       REQ_WRITE,
    input  wire logic [3:0] REQ_ADDR,
    input  wire logic [7:0] REQ_WDATA,
    input  wire logic       REQ_TRIG,
    input  wire logic       REQ_CHK_BAD,
    input  wire logic [6:0] EXT_CS_REQ,
    input  wire logic [6:0] GPIO_IN,
    input  wire logic [4:0] ERR_IN,
    output logic      [7:0] RD_DATA,
    output logic            RD_VALID,
    output logic            OUT_GAIN_SEL,
    output logic      [3:0] IN_GAIN_CODE,
    output logic      [6:0] SW1,
    output logic      [3:0] SW2,
    output logic            BUF_ACTIVE,
    output logic            CHK_ENABLED,
    output logic            EXT_CLK_SEL,
    output logic      [6:0] SEL_CLK_PHASE,
    output logic      [6:0] GPIO_OUT,
    output logic      [6:0] GPIO_OE
);

    // =================================================================
    // State
    typedef struct packed {
        logic [7:0] gain;
        logic [6:0] cpol;
        logic [5:0] ontime;
        logic [7:0] flags;
        logic [6:0] data;
        logic [6:0] sw1;
        logic [3:0] sw2;
        logic [6:0] dir;
        logic [6:0] ext_cs;
        logic [7:0] cfg1;
        logic [7:0] cfg2;
        logic [7:0] sfunc;
        logic [6:0] gsync1;
        logic [6:0] gsync2;
        logic [6:0] gsync3;
        logic [6:0] gpin;
        logic [4:0] esync1;
        logic [4:0] esync2;
        logic [4:0] esync3;
        logic [4:0] epin;
        logic [7:0] tick_cnt;
        logic       tick;
        logic [7:0] buf_cnt;
        logic       trig_prev;
        logic [6:0] sup_cnt;
        logic [10:0] out_dly;
        logic       out_gain;
        logic [3:0] in_gain;
        logic [6:0] gpio_out;
        logic [6:0] gpio_oe;
        logic [6:0] sel_phase;
        logic       ext_clk;
        logic [7:0] rd_data;
        logic       rd_valid;
        logic       buf_act;
    } acrb_state_t;

    acrb_state_t st;
    acrb_state_t next_st;
    logic        accept;
    logic        summary;
    logic        suppress;

    // Reset image shared by power-on and soft reset, so they cannot drift
    function automatic acrb_state_t rst_state();
        acrb_state_t s;
        s        = '0;
        s.gain   = RST_GAIN;
        s.ontime = RST_ONTIME;
        s.sw1    = RST_SW1;
        s.cfg2   = RST_CFG2;
        return s;
    endfunction

    // Suppression length in ticks; coarser steps above code 8
    function automatic logic [6:0] flag_cycles(input logic [3:0] code);
        logic [6:0] n;
        n = 7'h00;
        unique case (code)
            4'h9:    n = 7'h0c;
            4'ha:    n = 7'h10;
            4'hb:    n = 7'h18;
            4'hc:    n = 7'h20;
            4'hd:    n = 7'h30;
            4'he:    n = 7'h40;
            4'hf:    n = 7'h7f;
            default: n = {3'h0, code};
        endcase
        return n;
    endfunction

    // Read view of one register; blank bits read zero
    function automatic logic [7:0] read_reg(input acrb_state_t s, input logic [3:0] a,
                                            input logic sum);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            ADDR_GAIN:   v = s.gain;
            ADDR_CPOL:   v = {1'b0, s.cpol};
            ADDR_ONTIME: v = {2'b00, s.ontime};
            ADDR_ERR:    v = {s.flags[7:6], s.buf_act, s.flags[4], sum, s.flags[2:0]}; // [R10]
            ADDR_DATA:   v = {1'b0, (s.dir & s.data) | (~s.dir & s.gpin)};
            ADDR_SW1:    v = {1'b0, s.sw1};
            ADDR_SW2:    v = {4'h0, s.sw2};
            ADDR_DIR:    v = {1'b0, s.dir};
            ADDR_EXTCS:  v = {1'b0, s.ext_cs};
            ADDR_CFG1:   v = s.cfg1;
            ADDR_CFG2:   v = s.cfg2;
            ADDR_SFUNC:  v = s.sfunc;
            default:     v = 8'h00;
        endcase
        return v;
    endfunction

    // =================================================================
    // Combinational next state
    always_comb
    begin
        logic [7:0] cond;
        logic [7:0] setv;
        logic [7:0] clrv;
        logic [6:0] fv;
        logic       pin_trig;
        cond     = 8'h00;
        setv     = 8'h00;
        clrv     = 8'h00;
        fv       = 7'h00;
        pin_trig = 1'b0;
        next_st  = st;

        // A frame with a bad checksum is dropped while protection is on
        accept = REQ_VALID
               & ~(st.cfg2[CFG2_CHKEN] & REQ_CHK_BAD); // [R24]

        // Pin and error inputs: three stages, change once stages two and three agree
        next_st.gsync1 = GPIO_IN;
        next_st.gsync2 = st.gsync1;
        next_st.gsync3 = st.gsync2;
        next_st.esync1 = ERR_IN;
        next_st.esync2 = st.esync1;
        next_st.esync3 = st.esync2;
        for (int i = 0; i < 7; i++)
        begin
            if (st.gsync2[i] == st.gsync3[i])
                next_st.gpin[i] = st.gsync3[i];
        end
        for (int i = 0; i < 5; i++)
        begin
            if (st.esync2[i] == st.esync3[i])
                next_st.epin[i] = st.esync3[i];
        end

        // Internal 1 MHz tick derived from the system clock
        next_st.tick     = (st.tick_cnt == 8'(TICK_CYC - 1));
        next_st.tick_cnt = next_st.tick ? 8'h00 : st.tick_cnt + 8'h01;

        // Buffer timer: software trigger or rising edge on pin 4
        next_st.trig_prev = st.gpin[4];
        pin_trig = st.sfunc[SF_BUFT] & ~st.dir[4];
        if (st.tick && st.buf_cnt != 8'h00)
            next_st.buf_cnt = st.buf_cnt - 8'h01;
        if (st.ontime == 6'h00)
            next_st.buf_cnt = 8'h00; // [R8]
        else if ((accept && REQ_WRITE && REQ_TRIG)
                 || (pin_trig && st.gpin[4] && !st.trig_prev))
            next_st.buf_cnt = 8'(st.ontime * BUF_STEP_TICKS); // [R8] [R9]
        else if (pin_trig && st.gpin[4] && st.buf_cnt < 8'(BUF_HOLD_TICKS))
            next_st.buf_cnt = 8'(BUF_HOLD_TICKS);
        next_st.buf_act = (next_st.buf_cnt != 8'h00);

        // Flag suppression window starts when the buffer drops
        if (st.buf_act && !next_st.buf_act)
            next_st.sup_cnt = flag_cycles(st.cfg2[5:2]); // [R23]
        else if (st.tick && st.sup_cnt != 7'h00)
            next_st.sup_cnt = st.sup_cnt - 7'h01;
        suppress = (st.buf_act & ~st.cfg1[CFG1_KEEPERR]) | (st.sup_cnt != 7'h00);

        // Output-stage fault must persist before it counts
        if (!st.epin[2])
            next_st.out_dly = 11'h000;
        else if (st.out_dly != 11'(OUT_DLY_CYC))
            next_st.out_dly = st.out_dly + 11'h001; // [R14]

        // Qualified source conditions in register bit positions
        cond[ERR_IAR]  = st.epin[4];
        cond[ERR_ICA]  = st.epin[3];
        cond[ERR_OUT]  = (st.out_dly == 11'(OUT_DLY_CYC)); // [R14]
        cond[ERR_GAIN] = st.epin[1];
        cond[ERR_IOV]  = st.epin[0];
        setv = cond & {8{~suppress}};
        setv[ERR_CHK] = REQ_VALID & st.cfg2[CFG2_CHKEN] & REQ_CHK_BAD; // [R12]
        if (accept && REQ_WRITE && REQ_ADDR == ADDR_ERR)
            clrv = REQ_WDATA;
        // Set wins over a same-cycle write-one clear
        next_st.flags = (setv | (st.flags & ~clrv)) & (ERR_SRC_MASK | 8'h80); // [R11]
        if (st.cfg2[CFG2_LTD])
            next_st.flags = (setv & ERR_SRC_MASK) | (next_st.flags & 8'h80);

        // Summary: OR of unmasked sources, checksum fault excluded
        summary = |(st.flags & ERR_SRC_MASK & ~st.cfg1); // [R13] [R22]

        // Register writes; blank bits are dropped by the field widths and CFG2_WMASK
        if (accept && REQ_WRITE)
        begin
            unique case (REQ_ADDR)
                ADDR_GAIN:   next_st.gain   = REQ_WDATA; // [R1] [R4]
                ADDR_CPOL:   next_st.cpol   = REQ_WDATA[6:0];
                ADDR_ONTIME: next_st.ontime = REQ_WDATA[5:0];
                ADDR_DATA:   next_st.data   = REQ_WDATA[6:0]; // [R19]
                ADDR_SW1:    next_st.sw1    = REQ_WDATA[6:0];
                ADDR_SW2:    next_st.sw2    = REQ_WDATA[3:0];
                ADDR_DIR:    next_st.dir    = REQ_WDATA[6:0]; // [R17]
                ADDR_EXTCS:  next_st.ext_cs = REQ_WDATA[6:0]; // [R18]
                ADDR_CFG1:   next_st.cfg1   = REQ_WDATA;
                ADDR_CFG2:   next_st.cfg2   = REQ_WDATA & CFG2_WMASK;
                ADDR_SFUNC:  next_st.sfunc  = REQ_WDATA;
                default:     next_st.gain   = st.gain; // [R15] [R16]
            endcase
        end

        // Read answer one cycle after the request
        next_st.rd_valid = accept & ~REQ_WRITE;
        next_st.rd_data  = (accept && !REQ_WRITE) ? read_reg(st, REQ_ADDR, summary)
                                                  : 8'h00; // [R4] [R16]

        // Amplifier controls; reserved gain codes leave the last legal one
        next_st.out_gain = st.gain[7]; // [R1]
        if (st.gain[6:3] <= GAIN_CODE_MAX)
            next_st.in_gain = st.gain[6:3]; // [R2]

        // Pin functions: special function over extended select over data
        fv[2:0] = st.gain[2:0]; // [R3]
        fv[3]   = summary; // [R13]
        fv[5]   = st.buf_act ^ st.cfg1[CFG1_BUFPOL];
        fv[6]   = (st.tick_cnt < 8'(TICK_CYC / 2));
        for (int i = 0; i < 7; i++)
        begin
            if (st.sfunc[i] && i != SF_BUFT && i != SF_SYNC - 6 + 6
                && !(i < 3 && st.cfg1[CFG1_SELDIS])) // [R21]
                next_st.gpio_out[i] = (i == 6) ? (st.sfunc[SF_OSC] & fv[6]) : fv[i];
            else if (st.ext_cs[i])
                next_st.gpio_out[i] = ~EXT_CS_REQ[i]; // [R18]
            else
                next_st.gpio_out[i] = st.data[i]; // [R19] [R20]
        end
        if (st.sfunc[SF_OSC])
            next_st.gpio_out[6] = fv[6];
        next_st.gpio_oe   = st.dir; // [R17] [R20]
        next_st.sel_phase = st.cpol & st.ext_cs & st.dir; // [R7]
        next_st.ext_clk   = st.sfunc[SF_SYNC] & ~st.dir[6];

        // Soft reset restores the power-on image; its bit is never stored
        if (accept && REQ_WRITE && REQ_ADDR == ADDR_SRST && REQ_WDATA[0])
            next_st = rst_state(); // [R5] [R6]
    end

    // =================================================================
    // State register
    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
            st <= rst_state(); // [R6]
        else
            st <= next_st;
    end

    // Outputs straight from state flops
    assign RD_DATA       = st.rd_data;
    assign RD_VALID      = st.rd_valid;
    assign OUT_GAIN_SEL  = st.out_gain;
    assign IN_GAIN_CODE  = st.in_gain;
    assign SW1           = st.sw1;
    assign SW2           = st.sw2;
    assign BUF_ACTIVE    = st.buf_act;
    assign CHK_ENABLED   = st.cfg2[CFG2_CHKEN];
    assign EXT_CLK_SEL   = st.ext_clk;
    assign SEL_CLK_PHASE = st.sel_phase;
    assign GPIO_OUT      = st.gpio_out;
    assign GPIO_OE       = st.gpio_oe;

    // =================================================================
    // Assertions
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SRST);

    sequence s_good_wr(logic [3:0] a);
        accept && REQ_WRITE && REQ_ADDR == a;
    endsequence

    sequence s_bad_frame;
        REQ_VALID && st.cfg2[CFG2_CHKEN] && REQ_CHK_BAD;
    endsequence

    a_soft_reset_all: assert property ( // [R5] [R6]
        s_good_wr(ADDR_SRST) ##0 REQ_WDATA[0] |=> st.gain == RST_GAIN
            && st.ontime == RST_ONTIME && st.cfg2 == RST_CFG2 && st.dir == 7'h00)
        else $error("soft reset did not restore defaults");

    a_flag_clear: assert property ( // [R11]
        s_good_wr(ADDR_ERR) ##0 REQ_WDATA[ERR_IOV] && !st.epin[0]
            |=> !st.flags[ERR_IOV])
        else $error("write one did not clear flag");

    a_chk_enabled: assert property ( // [R12]
        $rose(st.flags[ERR_CHK]) |-> $past(st.cfg2[CFG2_CHKEN] && REQ_CHK_BAD))
        else $error("checksum fault set while protection off");

    a_bad_frame_drop: assert property ( // [R24]
        s_bad_frame ##0 REQ_WRITE && REQ_ADDR != ADDR_ERR |=> $stable(st.gain)
            && $stable(st.cfg2) && $stable(st.dir) && !st.rd_valid)
        else $error("bad checksum frame was taken");

    a_summary_read: assert property ( // [R13] [R10]
        accept && !REQ_WRITE && REQ_ADDR == ADDR_ERR
            |=> RD_VALID && RD_DATA[ERR_SUM] == $past(summary)
            && RD_DATA[ERR_BUFON] == $past(st.buf_act))
        else $error("error register read mismatch");

    a_buf_disabled: assert property ( // [R8]
        st.ontime == 6'h00 |=> !st.buf_act)
        else $error("buffer active with zero timeout");

    a_buf_load: assert property ( // [R8] [R9]
        accept && REQ_WRITE && REQ_TRIG && st.ontime != 6'h00 && REQ_ADDR == ADDR_GAIN
            |=> st.buf_cnt == 8'($past(st.ontime) * BUF_STEP_TICKS) ##1 st.buf_act)
        else $error("buffer timer not loaded");

    a_out_delay: assert property ( // [R14]
        $rose(st.flags[ERR_OUT]) |-> $past(st.out_dly) == 11'(OUT_DLY_CYC))
        else $error("output fault reported early");

    a_dir_to_oe: assert property ( // [R17] [R20]
        s_good_wr(ADDR_DIR) ##1 !(accept && REQ_WRITE)
            |=> GPIO_OE == $past(REQ_WDATA[6:0], 2))
        else $error("direction not applied to pin enable");

    a_test_ro: assert property ( // [R16]
        accept && REQ_WRITE && REQ_ADDR >= ADDR_TEST_LO
            |=> $stable(st.gain) && $stable(st.cfg1) && $stable(st.sfunc))
        else $error("test address was writable");

    a_gain_reserved: assert property ( // [R2]
        st.gain[6:3] > GAIN_CODE_MAX && !(accept && REQ_WRITE && REQ_ADDR == ADDR_SRST)
            |=> $stable(IN_GAIN_CODE))
        else $error("reserved gain code forwarded");

    a_sel_disable: assert property ( // [R21]
        st.cfg1[CFG1_SELDIS] && !st.ext_cs[0] && !(accept && REQ_WRITE && REQ_ADDR == ADDR_SRST)
            |=> GPIO_OUT[0] == $past(st.data[0]))
        else $error("selector still driven while disabled");

endmodule // acrb_top

`default_nettype wire

// ===== verif/acrb_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ====================
// Host side of the decoded command port
module acrb_host_model
(
    input  wire logic       clk,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data,
    output logic            req_valid,
    output logic            req_write,
    output logic      [3:0] req_addr,
    output logic      [7:0] req_wdata,
    output logic            req_trig,
    output logic            req_chk_bad
);
    // Idle port before the first command
    initial
    begin
        req_valid   = 1'b0;
        req_write   = 1'b0;
        req_addr    = 4'h0;
        req_wdata   = 8'h00;
        req_trig    = 1'b0;
        req_chk_bad = 1'b0;
    end

    // One command: read, write or write with trigger
    // A bad checksum goes out only when a scenario asks for it
    task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d,
                          input logic trg, input logic bad,
                          output logic [7:0] q, output logic got);
        @(posedge clk);
        #1;
        req_valid   = 1'b1;
        req_write   = wr;
        req_addr    = a;
        req_wdata   = d;
        req_trig    = trg;
        req_chk_bad = bad;
        @(posedge clk);
        #1;
        req_valid   = 1'b0;
        // Released address, data and trigger lines show the inverse so stale values never look valid
        req_addr    = ~a;
        req_wdata   = ~d;
        req_trig    = ~trg;
        got         = !wr && (rd_valid === 1'b1);
        q           = got ? rd_data : 8'h00;
    endtask
endmodule // acrb_host_model

`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none

// ====================
// Self-checking bench of the register bank
module testbench;
    import acrb_pkg::*;
    logic       clk_sys;
    logic       srst;
    logic [6:0] ext_cs_req;
    logic [6:0] gpio_in;
    logic [4:0] err_in;
    wire        req_valid, req_write, req_trig, req_chk_bad, rd_valid;
    wire  [3:0] req_addr, in_gain_code, sw2;
    wire  [7:0] req_wdata, rd_data;
    wire        out_gain_sel, buf_active, chk_enabled, ext_clk_sel;
    wire  [6:0] sw1, sel_clk_phase, gpio_out, gpio_oe;
    logic [7:0] rd;
    logic       got;
    int         miscompares;
    int         n_compared;
    localparam logic [7:0] RST_TAB [16] = '{8'h00, 8'h00, 8'h00, 8'h19, 8'h00, 8'h00,
        8'h60, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};

    acrb_top i_dut (.CLK_SYS(clk_sys), .SRST(srst), .REQ_VALID(req_valid),
        .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
        .REQ_TRIG(req_trig), .REQ_CHK_BAD(req_chk_bad), .EXT_CS_REQ(ext_cs_req),
        .GPIO_IN(gpio_in), .ERR_IN(err_in), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .OUT_GAIN_SEL(out_gain_sel), .IN_GAIN_CODE(in_gain_code), .SW1(sw1), .SW2(sw2),
        .BUF_ACTIVE(buf_active), .CHK_ENABLED(chk_enabled), .EXT_CLK_SEL(ext_clk_sel),
        .SEL_CLK_PHASE(sel_clk_phase), .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe));

    acrb_host_model i_host (.clk(clk_sys), .rd_valid(rd_valid), .rd_data(rd_data),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_trig(req_trig), .req_chk_bad(req_chk_bad));

    // ====================
    // Shared helpers
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic trg = 1'b0);
        i_host.access(1'b1, a, d, trg, 1'b0, rd, got);
    endtask

    // A read must answer exactly one cycle after it is taken
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
        i_host.access(1'b0, a, 8'h00, 1'b0, 1'b0, rd, got);
        check({what, " answer"}, {7'h00, got}, 8'h01);
        check(what, rd, exp);
    endtask

    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ====================
    // Scenarios
    task automatic t_reset_values();
        for (int a = 0; a < 16; a++)
            rd_chk("reset image", a[3:0], RST_TAB[a]);
        check("switch one pins", {1'b0, sw1}, 8'h60);
    endtask

    // Flag latching, clear by one, summary mask and the delayed output fault
    task automatic t_errors();
        wr(ADDR_CFG2, 8'h00);
        err_in = 5'b00001;
        cyc(10);
        rd_chk("overvoltage flag", ADDR_ERR, 8'h09);
        err_in = 5'b00000;
        cyc(8);
        wr(ADDR_CFG1, 8'h01);
        rd_chk("masked summary", ADDR_ERR, 8'h01);
        wr(ADDR_ERR, 8'hff);
        rd_chk("flags cleared", ADDR_ERR, 8'h00);
        wr(ADDR_CFG1, 8'h00);
        err_in = 5'b00100;
        cyc(1000);
        rd_chk("output fault early", ADDR_ERR, 8'h00);
        cyc(700);
        rd_chk("output fault late", ADDR_ERR, 8'h0c);
        err_in = 5'b00000;
        cyc(8);
        wr(ADDR_ERR, 8'hff);
    endtask

    // Bad frames pass while protection is off and are dropped while it is on
    task automatic t_checksum();
        i_host.access(1'b1, ADDR_SW2, 8'h05, 1'b0, 1'b1, rd, got);
        rd_chk("no fault while off", ADDR_ERR, 8'h00);
        check("switch two pins", {4'h0, sw2}, 8'h05);
        wr(ADDR_CFG2, 8'h01);
        cyc(1);
        check("protection on", {7'h00, chk_enabled}, 8'h01);
        i_host.access(1'b1, ADDR_SW2, 8'h0a, 1'b0, 1'b1, rd, got);
        i_host.access(1'b0, ADDR_SW2, 8'h00, 1'b0, 1'b1, rd, got);
        check("dropped read", {7'h00, got}, 8'h00);
        rd_chk("dropped write", ADDR_SW2, 8'h05);
        rd_chk("checksum fault", ADDR_ERR, 8'h80);
        wr(ADDR_ERR, 8'h80);
        wr(ADDR_CFG2, 8'h00);
        cyc(1);
        check("protection off", {7'h00, chk_enabled}, 8'h00);
    endtask

    // Gain fields, reserved code, triggered buffer at the reset on-time
    task automatic t_gain();
        wr(ADDR_GAIN, 8'h9a, 1'b1);
        cyc(2);
        check("output gain", {7'h00, out_gain_sel}, 8'h01);
        check("input gain", {4'h0, in_gain_code}, 8'h03);
        check("buffer triggered", {7'h00, buf_active}, 8'h01);
        rd_chk("buffer flag", ADDR_ERR, 8'h20);
        wr(ADDR_GAIN, 8'h58);
        cyc(2);
        check("reserved code", {4'h0, in_gain_code}, 8'h03);
        check("unity gain", {7'h00, out_gain_sel}, 8'h00);
        rd_chk("gain stored", ADDR_GAIN, 8'h58);
        cyc(24400);
        check("buffer held", {7'h00, buf_active}, 8'h01);
        cyc(900);
        check("buffer ended", {7'h00, buf_active}, 8'h00);
    endtask

    // Blank timeout bits, disabled buffer and the shortest on-time
    task automatic t_buffer();
        wr(ADDR_ONTIME, 8'hff);
        rd_chk("timeout blank bits", ADDR_ONTIME, 8'h3f);
        wr(ADDR_ONTIME, 8'h00);
        wr(ADDR_GAIN, 8'h18, 1'b1);
        cyc(4);
        check("buffer disabled", {7'h00, buf_active}, 8'h00);
        wr(ADDR_ONTIME, 8'h01);
        wr(ADDR_CFG2, 8'h20);
        wr(ADDR_GAIN, 8'h18, 1'b1);
        cyc(700);
        check("shortest on", {7'h00, buf_active}, 8'h01);
        cyc(350);
        check("shortest off", {7'h00, buf_active}, 8'h00);
        // Eight ticks of suppression follow the buffer, so this error is not latched
        err_in = 5'b00001;
        cyc(10);
        rd_chk("suppressed flag", ADDR_ERR, 8'h00);
        err_in = 5'b00000;
        cyc(8);
    endtask

    // Direction, extended selects, phase bits and pin data both ways
    task automatic t_pins();
        wr(ADDR_DATA, 8'h55);
        wr(ADDR_DIR, 8'h7f);
        wr(ADDR_CPOL, 8'h7f);
        wr(ADDR_EXTCS, 8'h0e);
        cyc(2);
        check("pin drive", {1'b0, gpio_oe}, 8'h7f);
        check("clock phase", {1'b0, sel_clk_phase}, 8'h0e);
        check("pin levels", {1'b0, gpio_out}, 8'h5f);
        // Selected extended selects pull their pin low
        ext_cs_req = 7'h06;
        wr(ADDR_GAIN, 8'h1d);
        wr(ADDR_SFUNC, 8'h07);
        cyc(2);
        check("selector pins", {1'b0, gpio_out}, 8'h5d);
        wr(ADDR_CFG1, 8'h80);
        cyc(2);
        check("selector off", {1'b0, gpio_out}, 8'h59);
        rd_chk("forced data", ADDR_DATA, 8'h55);
        wr(ADDR_DIR, 8'h00);
        wr(ADDR_SFUNC, 8'h40);
        gpio_in = 7'h2a;
        cyc(6);
        check("pins input", {1'b0, gpio_oe}, 8'h00);
        check("clock in select", {7'h00, ext_clk_sel}, 8'h01);
        rd_chk("sensed data", ADDR_DATA, 8'h2a);
        gpio_in = 7'h00;
        cyc(6);
        wr(ADDR_TEST_LO, 8'hff);
        rd_chk("test register", ADDR_TEST_LO, 8'h00);
    endtask

    // Clock source
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Main sequence; the long buffer run dominates the time
    initial
    begin
        srst = 1'b1;
        ext_cs_req = 7'h00;
        gpio_in = 7'h00;
        err_in = 5'b00000;
        miscompares = 0;
        n_compared = 0;
        repeat (16) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        t_reset_values();
        $display("test reset values done");
        t_errors();
        $display("test errors done");
        t_checksum();
        $display("test checksum done");
        t_gain();
        $display("test gain done");
        t_buffer();
        $display("test buffer done");
        t_pins();
        $display("test pins done");
        wr(ADDR_SW1, 8'h11);
        wr(ADDR_SRST, 8'h01);
        cyc(2);
        t_reset_values();
        $display("test soft reset done");
        close_out();
    end

    // Watchdog well beyond the expected 30000 cycles
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        miscompares++;
        $display("FAIL watchdog expected done seen running");
        close_out();
    end
endmodule // testbench

`default_nettype wire
